// ==== rtl/ced_pkg.sv ====
// Purpose: Shared constants and types for the exception dispatch unit
// Assumes: 32-bit effective addresses and machine state
// Notes: Cause bit index doubles as the fixed priority rank, zero highest
package ced_pkg;
   // ----------------------------------------
   // Cause indices, highest priority first
   // ----------------------------------------
   localparam int NUM_CAUSE = 14;
   localparam logic [3:0] C_MCHK = 4'h0;
   localparam logic [3:0] C_DEBUG = 4'h1;
   localparam logic [3:0] C_CRIT = 4'h2;
   localparam logic [3:0] C_WDT = 4'h3;
   localparam logic [3:0] C_ITLB = 4'h4;
   localparam logic [3:0] C_ISI = 4'h5;
   localparam logic [3:0] C_PROG = 4'h6;
   localparam logic [3:0] C_SYSC = 4'h7;
   localparam logic [3:0] C_DTLB = 4'h8;
   localparam logic [3:0] C_DSI = 4'h9;
   localparam logic [3:0] C_ALIGN = 4'ha;
   localparam logic [3:0] C_EXT = 4'hb;
   localparam logic [3:0] C_FIT = 4'hc;
   localparam logic [3:0] C_PIT = 4'hd;
   // ----------------------------------------
   // Vector offsets
   // ----------------------------------------
   localparam logic [15:0] V_CRIT = 16'h0100;
   localparam logic [15:0] V_MCHK = 16'h0200;
   localparam logic [15:0] V_DSI = 16'h0300;
   localparam logic [15:0] V_ISI = 16'h0400;
   localparam logic [15:0] V_EXT = 16'h0500;
   localparam logic [15:0] V_ALIGN = 16'h0600;
   localparam logic [15:0] V_PROG = 16'h0700;
   localparam logic [15:0] V_FP_UNAVAIL = 16'h0800;
   localparam logic [15:0] V_SYSC = 16'h0c00;
   localparam logic [15:0] V_AUX_UNAVAIL = 16'h0f20;
   localparam logic [15:0] V_PIT = 16'h1000;
   localparam logic [15:0] V_FIT = 16'h1010;
   localparam logic [15:0] V_WDT = 16'h1020;
   localparam logic [15:0] V_DTLB = 16'h1100;
   localparam logic [15:0] V_ITLB = 16'h1200;
   localparam logic [15:0] V_DEBUG = 16'h2000;
   // ----------------------------------------
   // Machine state field positions and reset
   // ----------------------------------------
   localparam int MS_DR = 4;
   localparam int MS_IR = 5;
   localparam int MS_DE = 9;
   localparam int MS_ME = 12;
   localparam int MS_PR = 14;
   localparam int MS_EE = 15;
   localparam int MS_CE = 17;
   localparam logic [31:0] MS_RESET = 32'h0000_0000;
   localparam logic [31:0] ZERO32 = 32'h0000_0000;
   localparam logic [3:0] ZERO_CAUSE = 4'h0;
   // Memory access kinds in flight
   localparam logic [1:0] ACC_NONE = 2'h0;
   localparam logic [1:0] ACC_ALIGNED = 2'h1;
   localparam logic [1:0] ACC_CROSS = 2'h2;
   localparam logic [1:0] ACC_MULTI = 2'h3;

   typedef enum logic [1:0] {
      ST_IDLE = 2'b00,
      ST_DRAIN = 2'b01,
      ST_SAVE = 2'b10,
      ST_FETCH = 2'b11
   } ced_state_t;

   typedef struct packed {
      logic [3:0] cause;
      logic critical;
      logic syncr;
      logic precise;
      logic [15:0] offset;
   } ced_take_t;

   typedef struct packed {
      logic [1:0] kind;
      logic is_store;
      logic update_form;
      logic on_bus;
   } ced_access_t;
endpackage : ced_pkg

// ==== rtl/ced_dispatch.sv ====
// Purpose: Exception classify, prioritise, save state and redirect fetch
// Assumes: Inputs synchronous to sys_clk; pipeline answers drain requests
// Notes: Interrupt inputs are levels held by their sources until cleared
`timescale 1ns/10ps

module ced_dispatch
   import ced_pkg::*;
(
   input wire logic sys_clk,
   input wire logic rst_b,
   input wire logic [NUM_CAUSE-1:0] exc_req,
   input wire logic debug_sync,
   input wire logic [31:0] return_ea,
   input wire logic [31:0] fault_ea,
   input wire logic [31:0] syndrome_in,
   input wire ced_access_t access,
   input wire logic pipe_drained,
   input wire logic rfi_req,
   input wire logic rfci_req,
   input wire logic [15:0] vector_base_reg,
   input wire logic state_wr_en,
   input wire logic [31:0] state_wr_data,
   output logic flush,
   output logic fetch_valid,
   output logic [31:0] fetch_addr,
   output ced_take_t take_info,
   output logic bus_req_inhibit,
   output logic reg_write_block,
   output logic base_update_block,
   output logic [31:0] noncrit_return_addr,
   output logic [31:0] noncrit_saved_state,
   output logic [31:0] crit_return_addr,
   output logic [31:0] crit_saved_state,
   output logic [31:0] machine_state_reg,
   output logic [31:0] exception_syndrome_reg,
   output logic [31:0] data_fault_addr_reg
);
   // ----------------------------------------
   // Decode helpers
   // ----------------------------------------
   function automatic logic [15:0] vec_of(input logic [3:0] c);
      case (c)
         C_MCHK: vec_of = V_MCHK;
         C_DEBUG: vec_of = V_DEBUG;
         C_CRIT: vec_of = V_CRIT;
         C_WDT: vec_of = V_WDT;
         C_ITLB: vec_of = V_ITLB;
         C_ISI: vec_of = V_ISI;
         C_PROG: vec_of = V_PROG;
         C_SYSC: vec_of = V_SYSC;
         C_DTLB: vec_of = V_DTLB;
         C_DSI: vec_of = V_DSI;
         C_ALIGN: vec_of = V_ALIGN;
         C_EXT: vec_of = V_EXT;
         C_FIT: vec_of = V_FIT;
         C_PIT: vec_of = V_PIT;
         default: vec_of = V_PROG;
      endcase
   endfunction : vec_of
   function automatic logic is_crit(input logic [3:0] c);
      is_crit = (c == C_MCHK) || (c == C_DEBUG) || (c == C_CRIT) || (c == C_WDT);
   endfunction : is_crit
   function automatic logic is_async(input logic [3:0] c);
      is_async = (c == C_MCHK) || (c == C_CRIT) || (c == C_WDT) || (c == C_EXT)
         || (c == C_FIT) || (c == C_PIT);
   endfunction : is_async
   function automatic logic sets_syndrome(input logic [3:0] c);
      sets_syndrome = (c == C_MCHK) || (c == C_DSI) || (c == C_ISI) || (c == C_PROG)
         || (c == C_DTLB);
   endfunction : sets_syndrome
   function automatic logic sets_fault_addr(input logic [3:0] c);
      sets_fault_addr = (c == C_DSI) || (c == C_ALIGN) || (c == C_DTLB);
   endfunction : sets_fault_addr

   // ----------------------------------------
   // Masking and selection
   // ----------------------------------------
   ced_state_t state;
   ced_state_t next_state;
   logic [NUM_CAUSE-1:0] enabled;
   logic any_req;
   logic [3:0] next_cause;
   logic aligned_on_bus;
   logic [3:0] cause;
   logic ret_crit;
   logic ret_busy;
   // An aligned access already on the bus finishes before anything is taken
   assign aligned_on_bus = access.on_bus && (access.kind == ACC_ALIGNED);
   always_comb begin
      enabled = exc_req;
      enabled[C_MCHK] = exc_req[C_MCHK] & machine_state_reg[MS_ME];
      enabled[C_DEBUG] = exc_req[C_DEBUG] & machine_state_reg[MS_DE];
      enabled[C_CRIT] = exc_req[C_CRIT] & machine_state_reg[MS_CE];
      enabled[C_WDT] = exc_req[C_WDT] & machine_state_reg[MS_CE];
      enabled[C_EXT] = exc_req[C_EXT] & machine_state_reg[MS_EE];
      enabled[C_FIT] = exc_req[C_FIT] & machine_state_reg[MS_EE];
      enabled[C_PIT] = exc_req[C_PIT] & machine_state_reg[MS_EE];
   end
   // Lowest index wins; masked ones drop out so lower ranks go ahead
   always_comb begin
      next_cause = ZERO_CAUSE;
      for (int i = NUM_CAUSE - 1; i >= 0; i--) begin
         if (enabled[i]) begin
            next_cause = i[3:0];
         end
      end
   end
   assign any_req = |enabled;

   // ----------------------------------------
   // Sequencer
   // ----------------------------------------
   always_comb begin
      next_state = state;
      case (state)
         ST_IDLE: begin
            if ((any_req || rfi_req || rfci_req) && !aligned_on_bus) begin
               next_state = ST_DRAIN;
            end
         end
         ST_DRAIN: begin
            if (pipe_drained) begin
               next_state = ST_SAVE;
            end
         end
         ST_SAVE: next_state = ST_FETCH;
         ST_FETCH: next_state = ST_IDLE;
         default: next_state = ST_IDLE;
      endcase
   end
   always_ff @(posedge sys_clk) begin
      if (!rst_b) begin
         state <= ST_IDLE;
      end else begin
         state <= next_state;
      end
   end
   // Latch the winner at entry so one interrupt is serviced at a time
   always_ff @(posedge sys_clk) begin
      if (!rst_b) begin
         cause <= ZERO_CAUSE;
         ret_busy <= 1'b0;
         ret_crit <= 1'b0;
      end else if (state == ST_IDLE && next_state == ST_DRAIN) begin
         cause <= next_cause;
         ret_busy <= !any_req;
         ret_crit <= rfci_req;
      end
   end

   // ----------------------------------------
   // Discard and access guards
   // ----------------------------------------
   always_ff @(posedge sys_clk) begin
      if (!rst_b) begin
         flush <= 1'b0;
         bus_req_inhibit <= 1'b0;
         reg_write_block <= 1'b0;
         base_update_block <= 1'b0;
      end else begin
         flush <= (next_state == ST_DRAIN);
         // Aligned scalars not yet on the bus are held off while an entry is pending
         bus_req_inhibit <= (next_state != ST_IDLE);
         // Crossing loads keep the register file untouched; multiples may not
         reg_write_block <= (next_state != ST_IDLE) && (access.kind == ACC_CROSS)
            && !access.is_store;
         base_update_block <= (next_state != ST_IDLE) && (access.kind != ACC_NONE)
            && access.update_form;
      end
   end

   // ----------------------------------------
   // Save registers and machine state
   // ----------------------------------------
   logic do_take;
   logic do_ret;
   assign do_take = (state == ST_SAVE) && !ret_busy;
   assign do_ret = (state == ST_SAVE) && ret_busy;

   always_ff @(posedge sys_clk) begin
      if (!rst_b) begin
         noncrit_return_addr <= ZERO32;
         noncrit_saved_state <= ZERO32;
         crit_return_addr <= ZERO32;
         crit_saved_state <= ZERO32;
      end else if (do_take && is_crit(cause)) begin
         crit_return_addr <= return_ea;
         crit_saved_state <= machine_state_reg;
      end else if (do_take) begin
         noncrit_return_addr <= return_ea;
         noncrit_saved_state <= machine_state_reg;
      end
   end

   always_ff @(posedge sys_clk) begin
      if (!rst_b) begin
         machine_state_reg <= MS_RESET;
      end else if (do_ret) begin
         machine_state_reg <= ret_crit ? crit_saved_state : noncrit_saved_state;
      end else if (do_take) begin
         machine_state_reg[MS_PR] <= 1'b0;
         machine_state_reg[MS_IR] <= 1'b0;
         machine_state_reg[MS_DR] <= 1'b0;
         machine_state_reg[MS_EE] <= 1'b0;
         if (is_crit(cause)) begin
            machine_state_reg[MS_CE] <= 1'b0;
            machine_state_reg[MS_DE] <= 1'b0;
         end
         if (cause == C_MCHK) begin
            machine_state_reg[MS_ME] <= 1'b0;
         end
      end else if (state_wr_en) begin
         // Software load loses to an entry or return in the same cycle
         machine_state_reg <= state_wr_data;
      end
   end
   always_ff @(posedge sys_clk) begin
      if (!rst_b) begin
         exception_syndrome_reg <= ZERO32;
      end else if (do_take && sets_syndrome(cause)) begin
         exception_syndrome_reg <= syndrome_in;
      end
   end
   always_ff @(posedge sys_clk) begin
      if (!rst_b) begin
         data_fault_addr_reg <= ZERO32;
      end else if (do_take && sets_fault_addr(cause)) begin
         data_fault_addr_reg <= fault_ea;
      end
   end

   // ----------------------------------------
   // Handler fetch, on the same edge that loads the new state
   // ----------------------------------------
   always_ff @(posedge sys_clk) begin
      if (!rst_b) begin
         fetch_valid <= 1'b0;
         fetch_addr <= ZERO32;
         take_info <= '0;
      end else begin
         fetch_valid <= (state == ST_SAVE);
         if (do_take) begin
            fetch_addr <= {vector_base_reg, vec_of(cause)};
            take_info.cause <= cause;
            take_info.critical <= is_crit(cause);
            take_info.syncr <= (cause == C_DEBUG) ? debug_sync : !is_async(cause);
            take_info.precise <= (cause != C_MCHK);
            take_info.offset <= vec_of(cause);
         end else if (do_ret) begin
            fetch_addr <= ret_crit ? crit_return_addr : noncrit_return_addr;
         end
      end
   end

   // ----------------------------------------
   // Checks
   // ----------------------------------------
   property p_fetch_addr;
      @(posedge sys_clk) disable iff (!rst_b)
      do_take |=> fetch_valid && fetch_addr == {$past(vector_base_reg), vec_of($past(cause))};
   endproperty
   a_fetch_addr: assert property (p_fetch_addr) else $error("Handler address wrong");
   property p_crit_pair;
      @(posedge sys_clk) disable iff (!rst_b)
      do_take && is_crit(cause) |=> $stable(noncrit_return_addr) && crit_return_addr == $past(return_ea);
   endproperty
   a_crit_pair: assert property (p_crit_pair) else $error("Critical save pair wrong");
   property p_noncrit_pair;
      @(posedge sys_clk) disable iff (!rst_b)
      do_take && !is_crit(cause) |=> noncrit_saved_state == $past(machine_state_reg)
         && $stable(crit_saved_state);
   endproperty
   a_noncrit_pair: assert property (p_noncrit_pair) else $error("Noncritical save pair wrong");
   property p_syndrome_keep;
      @(posedge sys_clk) disable iff (!rst_b)
      do_take && !sets_syndrome(cause) |=> $stable(exception_syndrome_reg);
   endproperty
   a_syndrome_keep: assert property (p_syndrome_keep) else $error("Syndrome changed");
   property p_fault_keep;
      @(posedge sys_clk) disable iff (!rst_b)
      do_take |=> (sets_fault_addr($past(cause)) ? data_fault_addr_reg == $past(fault_ea)
         : $stable(data_fault_addr_reg));
   endproperty
   a_fault_keep: assert property (p_fault_keep) else $error("Fault address wrong");
   property p_real_mode;
      @(posedge sys_clk) disable iff (!rst_b)
      do_take |=> !machine_state_reg[MS_PR] && !machine_state_reg[MS_IR]
         && !machine_state_reg[MS_DR] && fetch_valid;
   endproperty
   a_real_mode: assert property (p_real_mode) else $error("Not privileged real mode");
   property p_drain_first;
      @(posedge sys_clk) disable iff (!rst_b)
      state == ST_DRAIN && !pipe_drained |=> !fetch_valid ##1 !fetch_valid;
   endproperty
   a_drain_first: assert property (p_drain_first) else $error("Fetch before drain");
   property p_bus_guard;
      @(posedge sys_clk) disable iff (!rst_b)
      state == ST_IDLE && aligned_on_bus |=> state == ST_IDLE;
   endproperty
   a_bus_guard: assert property (p_bus_guard) else $error("Bus access interrupted");
   property p_precise;
      @(posedge sys_clk) disable iff (!rst_b)
      fetch_valid && !ret_busy |-> take_info.precise == (take_info.cause != C_MCHK);
   endproperty
   a_precise: assert property (p_precise) else $error("Precision class wrong");
   property p_ret_state;
      @(posedge sys_clk) disable iff (!rst_b)
      do_ret && ret_crit |=> machine_state_reg == $past(crit_saved_state)
         && fetch_addr == $past(crit_return_addr);
   endproperty
   a_ret_state: assert property (p_ret_state) else $error("Critical return wrong");
endmodule : ced_dispatch

// ==== dv/ced_partner.sv ====
// Purpose: Interrupt source and pipeline drain model facing the dispatch unit
// Assumes: Sources hold levels until the bench, acting as software, clears them
// Notes: Drain delay sets how slowly the pipeline empties after a flush
`timescale 1ns/10ps
module ced_partner
   import ced_pkg::*;
(
   input wire logic sys_clk,
   input wire logic rst_b,
   input wire logic [NUM_CAUSE-1:0] set_mask,
   input wire logic [NUM_CAUSE-1:0] clr_mask,
   input wire logic [3:0] drain_delay,
   input wire logic flush,
   output logic [NUM_CAUSE-1:0] exc_req = '0,
   output logic pipe_drained
);
   logic [3:0] drain_cnt = 4'h0;
   // ----------------------------------------
   // Source levels
   // ----------------------------------------
   always @(posedge sys_clk) begin
      if (!rst_b) begin
         exc_req <= '0;
      end else begin
         exc_req <= (exc_req | set_mask) & ~clr_mask;
      end
   end
   // ----------------------------------------
   // Pipeline drain
   // ----------------------------------------
   // Counts flush cycles, so a slow pipe holds the dispatch in its drain phase
   always @(posedge sys_clk) begin
      if (!rst_b || !flush) begin
         drain_cnt <= 4'h0;
      end else if (drain_cnt != 4'hf) begin
         drain_cnt <= drain_cnt + 4'h1;
      end
   end
   assign pipe_drained = (drain_cnt >= drain_delay);
endmodule : ced_partner

// ==== dv/cpu_exception_dispatch_tb.sv ====
// Purpose: Self-checking bench for the exception dispatch unit
// Assumes: Machine state resets to zero; the bench loads it to let maskable causes through
// Notes: Bench clears each taken source the way a handler would
`timescale 1ns/10ps
module cpu_exception_dispatch_tb
   import ced_pkg::*;
;
   // ----------------------------------------
   // Expected tables, indexed by cause
   // ----------------------------------------
   localparam logic [15:0] OFFS [NUM_CAUSE] = '{16'h0200, 16'h2000, 16'h0100, 16'h1020, 16'h1200, 16'h0400,
      16'h0700, 16'h0c00, 16'h1100, 16'h0300, 16'h0600, 16'h0500, 16'h1010, 16'h1000};
   localparam logic [NUM_CAUSE-1:0] CRIT_M = 14'h000f;
   // Unmaskable at reset state are exactly the synchronous causes other than debug
   localparam logic [NUM_CAUSE-1:0] SYNC_M = 14'h07f0;
   localparam logic [NUM_CAUSE-1:0] SYND_M = 14'h0361;
   localparam logic [NUM_CAUSE-1:0] FAULT_M = 14'h0700;
   // Every enable and mode bit set, so entry visibly clears the ones it drops
   localparam logic [31:0] ALL_ON = (32'h1 << MS_DR) | (32'h1 << MS_IR) | (32'h1 << MS_DE) | (32'h1 << MS_ME)
      | (32'h1 << MS_PR) | (32'h1 << MS_EE) | (32'h1 << MS_CE);
   logic state_wr_en = 1'b0;
   logic [31:0] state_wr_data = '0;
   logic sys_clk = 1'b0;
   logic rst_b = 1'b0;
   logic [NUM_CAUSE-1:0] exc_req;
   logic [NUM_CAUSE-1:0] set_mask = '0;
   logic [NUM_CAUSE-1:0] clr_mask = '0;
   logic [NUM_CAUSE-1:0] m;
   logic [3:0] drain_delay = 4'h0;
   logic debug_sync = 1'b0;
   logic [31:0] return_ea = 32'h0000_1234;
   logic [31:0] fault_ea = 32'h0000_5678;
   logic [31:0] syndrome_in = 32'h0000_9abc;
   ced_access_t access = '0;
   logic pipe_drained, rfi_req = 1'b0, rfci_req = 1'b0;
   logic [15:0] vector_base_reg = 16'h0001;
   logic flush, fetch_valid, bus_req_inhibit, reg_write_block, base_update_block;
   logic [31:0] fetch_addr, noncrit_return_addr, noncrit_saved_state, crit_return_addr, crit_saved_state;
   logic [31:0] machine_state_reg, exception_syndrome_reg, data_fault_addr_reg;
   ced_take_t take_info;
   logic [31:0] seed = 32'h1527d0cc;
   logic [31:0] e_nra = '0, e_nss = '0, e_cra = '0, e_css = '0, e_mstate = '0, e_synd = '0, e_fault = '0;
   logic saw_flush, saw_rwb, saw_bub;
   int n_errors = 0, compares = 0, cycles = 0, lat;

   always #20 sys_clk = ~sys_clk;

   ced_dispatch u_ced_dispatch (.sys_clk(sys_clk), .rst_b(rst_b), .exc_req(exc_req), .debug_sync(debug_sync),
      .return_ea(return_ea), .fault_ea(fault_ea), .syndrome_in(syndrome_in), .access(access),
      .pipe_drained(pipe_drained), .rfi_req(rfi_req), .rfci_req(rfci_req), .vector_base_reg(vector_base_reg),
      .state_wr_en(state_wr_en), .state_wr_data(state_wr_data),
      .flush(flush), .fetch_valid(fetch_valid), .fetch_addr(fetch_addr), .take_info(take_info),
      .bus_req_inhibit(bus_req_inhibit), .reg_write_block(reg_write_block), .base_update_block(base_update_block),
      .noncrit_return_addr(noncrit_return_addr), .noncrit_saved_state(noncrit_saved_state),
      .crit_return_addr(crit_return_addr), .crit_saved_state(crit_saved_state),
      .machine_state_reg(machine_state_reg), .exception_syndrome_reg(exception_syndrome_reg),
      .data_fault_addr_reg(data_fault_addr_reg));
   ced_partner u_ced_partner (.sys_clk(sys_clk), .rst_b(rst_b), .set_mask(set_mask), .clr_mask(clr_mask),
      .drain_delay(drain_delay), .flush(flush), .exc_req(exc_req), .pipe_drained(pipe_drained));

   // ----------------------------------------
   // Helpers
   // ----------------------------------------
   function automatic logic [31:0] lfsr(input logic [31:0] s);
      lfsr = {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
   endfunction : lfsr

   // Entry state: privileged real mode, class masks dropped
   function automatic logic [31:0] entry_state(input logic [31:0] s, input logic [3:0] c);
      entry_state = s;
      entry_state[MS_PR] = 1'b0;
      entry_state[MS_IR] = 1'b0;
      entry_state[MS_DR] = 1'b0;
      entry_state[MS_EE] = 1'b0;
      if (CRIT_M[c]) begin
         entry_state[MS_CE] = 1'b0;
         entry_state[MS_DE] = 1'b0;
      end
      if (c == C_MCHK) entry_state[MS_ME] = 1'b0;
   endfunction : entry_state

   task automatic load_state(input logic [31:0] v);
      state_wr_data = v;
      state_wr_en = 1'b1;
      @(negedge sys_clk);
      state_wr_en = 1'b0;
      e_mstate = v;
   endtask : load_state

   task automatic check(input string what, input logic [31:0] exp, input logic [31:0] got);
      compares++;
      if (exp !== got) begin
         n_errors++;
         $display("ERROR %s expected %h seen %h", what, exp, got);
      end
   endtask : check

   task automatic raise(input logic [NUM_CAUSE-1:0] mask);
      set_mask = mask;
      @(negedge sys_clk);
      set_mask = '0;
   endtask : raise

   // Watches a sequence until the fetch pulse, bounded
   task automatic wait_fetch(input int limit);
      lat = 0;
      saw_flush = 1'b0;
      saw_rwb = 1'b0;
      saw_bub = 1'b0;
      while (fetch_valid !== 1'b1 && lat < limit) begin
         @(negedge sys_clk);
         lat++;
         saw_flush |= (flush === 1'b1) && (bus_req_inhibit === 1'b1);
         saw_rwb |= (reg_write_block === 1'b1);
         saw_bub |= (base_update_block === 1'b1);
      end
   endtask : wait_fetch

   task automatic check_regs();
      check("noncrit_return_addr", e_nra, noncrit_return_addr);
      check("noncrit_saved_state", e_nss, noncrit_saved_state);
      check("crit_return_addr", e_cra, crit_return_addr);
      check("crit_saved_state", e_css, crit_saved_state);
      check("machine_state_reg", e_mstate, machine_state_reg);
      check("exception_syndrome_reg", e_synd, exception_syndrome_reg);
      check("data_fault_addr_reg", e_fault, data_fault_addr_reg);
   endtask : check_regs

   task automatic serve(input logic [3:0] c, input int exp_lat);
      wait_fetch(40);
      if (exp_lat > 0) check("latency", 32'(exp_lat), 32'(lat));
      check("fetch_valid", 32'h1, 32'(fetch_valid));
      check("fetch_addr", {vector_base_reg, OFFS[c]}, fetch_addr);
      check("cause", 32'(c), 32'(take_info.cause));
      check("critical", 32'(CRIT_M[c]), 32'(take_info.critical));
      check("syncr", 32'((c == C_DEBUG) ? debug_sync : SYNC_M[c]), 32'(take_info.syncr));
      check("precise", 32'(c != C_MCHK), 32'(take_info.precise));
      check("offset", 32'(OFFS[c]), 32'(take_info.offset));
      if (CRIT_M[c]) begin
         e_cra = return_ea;
         e_css = e_mstate;
      end else begin
         e_nra = return_ea;
         e_nss = e_mstate;
      end
      e_mstate = entry_state(e_mstate, c);
      if (SYND_M[c]) e_synd = syndrome_in;
      if (FAULT_M[c]) e_fault = fault_ea;
      check_regs();
      check("flush_before_fetch", 32'h1, 32'(saw_flush));
      if ((c == C_DSI || c == C_ALIGN) && access.kind == ACC_CROSS) begin
         if (!access.is_store) check("reg_write_block", 32'h1, 32'(saw_rwb));
         if (access.is_store && access.update_form) check("base_update_block", 32'h1, 32'(saw_bub));
      end
      clr_mask = 14'h0001 << c;
      @(negedge sys_clk);
      clr_mask = '0;
   endtask : serve

   task automatic do_return(input logic crit);
      rfi_req = !crit;
      rfci_req = crit;
      wait_fetch(40);
      rfi_req = 1'b0;
      rfci_req = 1'b0;
      check("return_latency", 32'h3, 32'(lat));
      check("return_addr", crit ? e_cra : e_nra, fetch_addr);
      e_mstate = crit ? e_css : e_nss;
      check_regs();
      @(negedge sys_clk);
   endtask : do_return

   // Nothing may start while the sources stay blocked
   task automatic quiet(input string what, input int n);
      saw_flush = 1'b0;
      repeat (n) begin
         @(negedge sys_clk);
         saw_flush |= (flush === 1'b1) || (fetch_valid === 1'b1);
      end
      check(what, 32'h0, 32'(saw_flush));
   endtask : quiet

   task automatic wrap_up();
      $display("Comparisons %0d, mismatches %0d", compares, n_errors);
      if (n_errors == 0 && compares > 0) begin
         $display("All tests passed");
      end else begin
         $display("Some tests failed");
      end
      $finish;
   endtask : wrap_up

   always @(posedge sys_clk) begin
      cycles++;
      if (cycles == 20000) begin
         n_errors++;
         $display("ERROR timeout expected finish seen hang");
         wrap_up();
      end
   end

   // ----------------------------------------
   // Main sequence
   // ----------------------------------------
   initial begin
      repeat (10) @(negedge sys_clk);
      check_regs();
      rst_b = 1'b1;
      raise(14'h0080);
      serve(C_SYSC, 3);
      do_return(1'b0);
      do_return(1'b1);
      // Masked causes stay pending while an unmasked one goes ahead
      raise(14'h380f);
      quiet("masked_taken", 12);
      raise(14'h0400);
      serve(C_ALIGN, 3);
      clr_mask = 14'h380f;
      @(negedge sys_clk);
      clr_mask = '0;
      // Aligned access already on the bus defers dispatch
      access = '{kind: ACC_ALIGNED, is_store: 1'b0, update_form: 1'b0, on_bus: 1'b1};
      raise(14'h0200);
      quiet("on_bus_interrupted", 8);
      access = '0;
      serve(C_DSI, 0);
      drain_delay = 4'h6;
      raise(14'h0010);
      serve(C_ITLB, 0);
      check("slow_drain", 32'h1, 32'(lat >= 9));
      // Enabled state lets each maskable cause through, then a return restores it
      drain_delay = 4'h0;
      for (int c = 0; c < NUM_CAUSE; c++) begin
         if (!SYNC_M[c]) begin
            load_state(ALL_ON);
            check("state_load", ALL_ON, machine_state_reg);
            raise(14'h0001 << c);
            serve(4'(c), 3);
            do_return(CRIT_M[c]);
         end
      end
      for (int i = 0; i < 40; i++) begin
         seed = lfsr(seed);
         return_ea = seed;
         seed = lfsr(seed);
         fault_ea = seed;
         seed = lfsr(seed);
         syndrome_in = seed;
         seed = lfsr(seed);
         vector_base_reg = seed[15:0];
         debug_sync = seed[16];
         drain_delay = {2'b00, seed[18:17]};
         access = '{kind: seed[20:19], is_store: seed[21], update_form: seed[22], on_bus: 1'b0};
         seed = lfsr(seed);
         m = seed[13:0] & SYNC_M;
         if (m == '0) m = 14'h0040;
         raise(m);
         for (int c = 0; c < NUM_CAUSE; c++) begin
            if (m[c]) serve(4'(c), 0);
         end
      end
      wrap_up();
   end
endmodule : cpu_exception_dispatch_tb
